// ===== hdl/mac_error_stat_counters.sv
`timescale 1ns/1ps

module mac_error_stat_counters
	import stat_pkg::*;
#(
	parameter int CNT_WIDTH = CNT_WIDTH_DEF
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// transmit path events
	input  wire logic                  tx_preamble_active,
	input  wire logic                  carrier_sense,
	input  wire logic                  tx_short_frame_attempt,
	// receive path events
	input  wire logic                  rx_crc_error_frame,
	input  wire logic                  phy_rx_er,
	// mode control from the mac mode register
	input  wire logic                  accept_bad_crc_frames,
	// axi4-lite write address
	input  wire logic [ADDR_WIDTH-1:0] awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	// axi4-lite write data
	input  wire logic [DATA_WIDTH-1:0] wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	// axi4-lite write response
	output logic      [1:0]            bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	// axi4-lite read address
	input  wire logic [ADDR_WIDTH-1:0] araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	// axi4-lite read data
	output logic      [DATA_WIDTH-1:0] rdata,
	output logic      [1:0]            rresp,
	output logic                       rvalid,
	input  wire logic                  rready
);

	localparam logic [CNT_WIDTH-1:0] CNT_MAX = '1;

	// upper half must stay reserved, so the value cannot spill into it
	if (CNT_WIDTH < 1 || CNT_WIDTH > VALUE_MSB + 1) begin : g_bad_width
		$error("CNT_WIDTH must lie between 1 and 16");
	end

	logic [CNT_WIDTH-1:0]    cnt [NUM_COUNTERS];
	logic [NUM_COUNTERS-1:0] ev;
	logic [NUM_COUNTERS-1:0] clr;

	// edge history of level-type event sources
	logic                    carrier_miss;
	logic                    carrier_miss_r;
	logic                    rx_er_r;

	// write channel state
	logic                    aw_held_r;
	logic                    w_held_r;
	logic [ADDR_WIDTH-1:0]   aw_addr_r;
	logic                    bvalid_r;
	logic [1:0]              bresp_r;
	logic                    aw_fire;
	logic                    w_fire;
	logic                    do_write;
	logic [ADDR_WIDTH-1:0]   wr_addr;
	logic [NUM_COUNTERS-1:0] wsel;

	// read channel state
	logic                    rvalid_r;
	logic [DATA_WIDTH-1:0]   rdata_r;
	logic [1:0]              rresp_r;
	logic                    ar_fire;
	logic [NUM_COUNTERS-1:0] rsel;
	logic [DATA_WIDTH-1:0]   rd_word;

	// one-hot select of the counter at a byte address, zero if unmapped
	function automatic logic [NUM_COUNTERS-1:0] reg_select(
		input logic [ADDR_WIDTH-1:0] a
	);
		logic [NUM_COUNTERS-1:0] s;
		s = '0;
		case (a)
			OFS_CARRIER_MISSING: s[IDX_CARRIER] = 1'b1;
			OFS_SHORT_FRAME:     s[IDX_SHORT]   = 1'b1;
			OFS_BAD_CRC:         s[IDX_CRC]     = 1'b1;
			OFS_RX_ERROR:        s[IDX_RXER]    = 1'b1;
			default:             s = '0;
		endcase
		return s;
	endfunction : reg_select

	// ------------------------------------------------------------
	// event qualification
	// ------------------------------------------------------------

	// a carrier dropout that spans several cycles of one preamble counts once
	assign carrier_miss = tx_preamble_active && !carrier_sense;

	always_ff @(posedge clk) begin
		if (reset) begin
			carrier_miss_r <= 1'b0;
		end else begin
			carrier_miss_r <= carrier_miss;
		end
	end

	// the receive-error pin is a level; each new assertion is one event
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_er_r <= 1'b0;
		end else begin
			rx_er_r <= phy_rx_er;
		end
	end

	assign ev[IDX_CARRIER] = carrier_miss && !carrier_miss_r;
	assign ev[IDX_SHORT]   = tx_short_frame_attempt;
	assign ev[IDX_CRC]     = rx_crc_error_frame && !accept_bad_crc_frames;
	assign ev[IDX_RXER]    = phy_rx_er && !rx_er_r;

	// ------------------------------------------------------------
	// the four saturating counters
	// ------------------------------------------------------------

	for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
		sat_counter #(
			.WIDTH (CNT_WIDTH)
		) u_cnt (
			.clk   (clk),
			.reset (reset),
			.clear (clr[i]),
			.inc   (ev[i]),
			.count (cnt[i])
		);
	end

	// ------------------------------------------------------------
	// axi4-lite write side
	// ------------------------------------------------------------

	// address and data are taken in either order; no new one while a response waits
	assign awready  = !aw_held_r && !bvalid_r;
	assign wready   = !w_held_r && !bvalid_r;
	assign aw_fire  = awvalid && awready;
	assign w_fire   = wvalid && wready;
	assign do_write = (aw_held_r || aw_fire) && (w_held_r || w_fire);
	assign wr_addr  = aw_held_r ? aw_addr_r : awaddr;
	assign wsel     = reg_select(wr_addr);

	// data and strobes do not matter: any write to a counter empties it
	assign clr = do_write ? wsel : '0;

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_held_r <= 1'b0;
		end else if (do_write) begin
			aw_held_r <= 1'b0;
		end else if (aw_fire) begin
			aw_held_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_addr_r <= '0;
		end else if (aw_fire) begin
			aw_addr_r <= awaddr;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			w_held_r <= 1'b0;
		end else if (do_write) begin
			w_held_r <= 1'b0;
		end else if (w_fire) begin
			w_held_r <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_r <= 1'b1;
			bresp_r  <= (|wsel) ? RESP_OKAY : RESP_SLVERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	assign bvalid = bvalid_r;
	assign bresp  = bresp_r;

	// ------------------------------------------------------------
	// axi4-lite read side
	// ------------------------------------------------------------

	assign arready = !rvalid_r;
	assign ar_fire = arvalid && arready;
	assign rsel    = reg_select(araddr);

	always_comb begin
		rd_word = '0;
		for (int i = 0; i < NUM_COUNTERS; i++) begin
			if (rsel[i]) begin
				rd_word[CNT_WIDTH-1:0] = cnt[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rvalid_r <= 1'b0;
		end else if (ar_fire) begin
			rvalid_r <= 1'b1;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_r <= '0;
			rresp_r <= RESP_OKAY;
		end else if (ar_fire) begin
			rdata_r <= rd_word;
			rresp_r <= (|rsel) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	assign rvalid = rvalid_r;
	assign rdata  = rdata_r;
	assign rresp  = rresp_r;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------

	default clocking cb @(posedge clk);
	endclocking

	default disable iff (reset);

	chk_carrier_count: assert property (
		$rose(tx_preamble_active && !carrier_sense) && !clr[IDX_CARRIER]
		&& cnt[IDX_CARRIER] != CNT_MAX
		|=> cnt[IDX_CARRIER] == $past(cnt[IDX_CARRIER]) + 1'b1
	) else $error("carrier-missing counter did not step");

	chk_carrier_once: assert property (
		carrier_miss ##1 (carrier_miss && !clr[IDX_CARRIER])
		|=> $stable(cnt[IDX_CARRIER])
	) else $error("carrier-missing counter stepped twice for one dropout");

	chk_short_count: assert property (
		tx_short_frame_attempt && !clr[IDX_SHORT] && cnt[IDX_SHORT] != CNT_MAX
		|=> cnt[IDX_SHORT] == $past(cnt[IDX_SHORT]) + 1'b1
	) else $error("short-frame counter did not step");

	chk_crc_count: assert property (
		rx_crc_error_frame && !accept_bad_crc_frames && !clr[IDX_CRC]
		&& cnt[IDX_CRC] != CNT_MAX
		|=> cnt[IDX_CRC] == $past(cnt[IDX_CRC]) + 1'b1
	) else $error("bad-crc counter did not step");

	chk_crc_masked: assert property (
		accept_bad_crc_frames && !clr[IDX_CRC]
		|=> $stable(cnt[IDX_CRC])
	) else $error("bad-crc counter moved while bad frames are accepted");

	chk_rxer_count: assert property (
		$rose(phy_rx_er) && !clr[IDX_RXER] && cnt[IDX_RXER] != CNT_MAX
		|=> cnt[IDX_RXER] == $past(cnt[IDX_RXER]) + 1'b1
	) else $error("receive-error counter did not step");

	chk_rxer_level: assert property (
		phy_rx_er ##1 (phy_rx_er && !clr[IDX_RXER])
		|=> $stable(cnt[IDX_RXER])
	) else $error("receive-error counter stepped on a held level");

	for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_chk
		chk_saturate_hold: assert property (
			cnt[i] == CNT_MAX && !clr[i] |=> cnt[i] == CNT_MAX
		) else $error("counter left its saturated value");

		chk_clear_wins: assert property (
			clr[i] |=> cnt[i] == '0
		) else $error("counter not zero after a clearing write");

		chk_single_step: assert property (
			!clr[i] |=> cnt[i] == $past(cnt[i]) || cnt[i] == $past(cnt[i]) + 1'b1
		) else $error("counter moved by more than one");
	end

	chk_reset_zero: assert property (
		disable iff (1'b0)
		reset |=> cnt[IDX_CARRIER] == '0 && cnt[IDX_SHORT] == '0
		&& cnt[IDX_CRC] == '0 && cnt[IDX_RXER] == '0
	) else $error("counters not zero after reset");

	chk_upper_zero: assert property (
		rvalid |-> rdata[RESVD_MSB:RESVD_LSB] == RESVD_VALUE
	) else $error("reserved read bits not zero");

	chk_read_value: assert property (
		arvalid && arready && araddr == OFS_BAD_CRC
		|=> rvalid && rresp == RESP_OKAY
		&& rdata[CNT_WIDTH-1:0] == $past(cnt[IDX_CRC])
	) else $error("read of bad-crc register returned wrong value");

	chk_read_hold: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp)
	) else $error("read answer dropped before it was taken");

	chk_write_answer: assert property (
		do_write |=> bvalid ##0 (bresp == RESP_OKAY) == $past(|wsel)
	) else $error("write response missing or wrong");

	chk_short_idle: assert property (
		!tx_short_frame_attempt && !clr[IDX_SHORT] |=> $stable(cnt[IDX_SHORT])
	) else $error("short-frame counter moved without an attempt");

	chk_crc_idle: assert property (
		!rx_crc_error_frame && !clr[IDX_CRC] |=> $stable(cnt[IDX_CRC])
	) else $error("bad-crc counter moved without a bad frame");

	chk_write_refuse: assert property (
		bvalid |-> !awready && !wready
	) else $error("write taken while a response waits");

	chk_read_refuse: assert property (
		rvalid |-> !arready
	) else $error("read taken while read data waits");

endmodule : mac_error_stat_counters

// ===== hdl/stat_pkg.sv
package stat_pkg;

	// counter and bus geometry
	localparam int CNT_WIDTH_DEF = 16;
	localparam int DATA_WIDTH    = 32;
	localparam int ADDR_WIDTH    = 8;
	localparam int NUM_COUNTERS  = 4;

	// register byte offsets
	localparam logic [ADDR_WIDTH-1:0] OFS_CARRIER_MISSING = 8'h00;
	localparam logic [ADDR_WIDTH-1:0] OFS_SHORT_FRAME     = 8'h04;
	localparam logic [ADDR_WIDTH-1:0] OFS_BAD_CRC         = 8'h08;
	localparam logic [ADDR_WIDTH-1:0] OFS_RX_ERROR        = 8'h0C;

	// counter slots
	localparam int IDX_CARRIER = 0;
	localparam int IDX_SHORT   = 1;
	localparam int IDX_CRC     = 2;
	localparam int IDX_RXER    = 3;

	// field layout and reset value of each counter register
	localparam int             VALUE_LSB   = 0;
	localparam int             VALUE_MSB   = 15;
	localparam int             RESVD_LSB   = 16;
	localparam int             RESVD_MSB   = 31;
	localparam logic [15:0]    COUNT_RESET = 16'h0000;
	localparam logic [15:0]    RESVD_VALUE = 16'h0000;

	// write and read responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : stat_pkg

// ===== hdl/sat_counter.sv
`timescale 1ns/1ps

module sat_counter
	import stat_pkg::*;
#(
	parameter int WIDTH = CNT_WIDTH_DEF
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// control
	input  wire logic             clear,
	input  wire logic             inc,
	// value
	output logic      [WIDTH-1:0] count
);

	localparam logic [WIDTH-1:0] COUNT_MAX = '1;

	always_ff @(posedge clk) begin
		if (reset) begin
			count <= WIDTH'(COUNT_RESET);
		end else if (clear) begin
			count <= WIDTH'(COUNT_RESET);
		end else if (inc && count != COUNT_MAX) begin
			count <= count + 1'b1;
		end
	end

endmodule : sat_counter

// ===== testbench/phy_event_model.sv
`timescale 1ns/1ps

module phy_event_model
	import stat_pkg::*;
(
	// clock
	input  wire logic       clk,
	// one bit per event kind, raised by the bench for one cycle or held for several
	input  wire logic [3:0] ev,
	// event lines toward the counters
	output logic            tx_preamble_active,
	output logic            carrier_sense,
	output logic            tx_short_frame_attempt,
	output logic            rx_crc_error_frame,
	output logic            phy_rx_er
);
	logic [3:0] ev_r = 4'h0;

	always @(posedge clk) begin
		ev_r <= ev;
	end

	// carrier drops only inside a preamble, otherwise it is present
	assign tx_preamble_active     = ev_r[IDX_CARRIER];
	assign carrier_sense          = !ev_r[IDX_CARRIER];
	assign tx_short_frame_attempt = ev_r[IDX_SHORT];
	assign rx_crc_error_frame     = ev_r[IDX_CRC];
	assign phy_rx_er              = ev_r[IDX_RXER];

endmodule : phy_event_model

// ===== testbench/tb.sv
`timescale 1ns/1ps

module tb
	import stat_pkg::*;
;
	localparam int          W    = 3;
	localparam logic [31:0] MAXV = 32'((1 << W) - 1);
	localparam logic [7:0]  OFS [4] = '{OFS_CARRIER_MISSING, OFS_SHORT_FRAME, OFS_BAD_CRC,
		OFS_RX_ERROR};

	logic        clk, reset, accept_bad_crc_frames;
	logic [3:0]  ev;
	logic        tx_preamble_active, carrier_sense, tx_short_frame_attempt;
	logic        rx_crc_error_frame, phy_rx_er;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	int          n_errors, tests_run;

	phy_event_model i_phy_event_model (.clk(clk), .ev(ev),
		.tx_preamble_active(tx_preamble_active), .carrier_sense(carrier_sense),
		.tx_short_frame_attempt(tx_short_frame_attempt),
		.rx_crc_error_frame(rx_crc_error_frame), .phy_rx_er(phy_rx_er));

	mac_error_stat_counters #(.CNT_WIDTH(W)) i_mac_error_stat_counters (.clk(clk),
		.reset(reset), .tx_preamble_active(tx_preamble_active), .carrier_sense(carrier_sense),
		.tx_short_frame_attempt(tx_short_frame_attempt),
		.rx_crc_error_frame(rx_crc_error_frame), .phy_rx_er(phy_rx_er),
		.accept_bad_crc_frames(accept_bad_crc_frames), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= 32'h0;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge clk);
			if (awready && !aw) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge clk);
		chk("bresp", 32'(er), 32'(bresp));
		bready <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge clk);
		while (!arready) @(posedge clk);
		arvalid <= 1'b0;
		@(posedge clk);
		while (!rvalid) @(posedge clk);
		chk("rdata", e, rdata);
		chk("rresp", 32'(er), 32'(rresp));
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd

	// separate single-cycle events so each one is a fresh rising edge
	task automatic fire(input logic [3:0] m, input int n);
		repeat (n) begin
			ev <= m;
			@(posedge clk);
			ev <= 4'h0;
			@(posedge clk);
		end
		@(posedge clk);
	endtask : fire

	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		end_of_test();
	end

	initial begin
		{reset, accept_bad_crc_frames, ev, awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready, n_errors, tests_run} = '0;
		reset = 1'b1;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk("ready", 32'h7, 32'({awready, wready, arready}));
		for (int i = 0; i < 4; i++) rd(OFS[i], 32'h0, RESP_OKAY);
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			fire(4'(1 << i), 3);
			rd(OFS[i], 32'h3, RESP_OKAY);
		end
		$display("event counting done");
		accept_bad_crc_frames <= 1'b1;
		fire(4'h4, 2);
		rd(OFS_BAD_CRC, 32'h3, RESP_OKAY);
		accept_bad_crc_frames <= 1'b0;
		$display("crc accept mode done");
		fire(4'hF, 10);
		for (int i = 0; i < 4; i++) rd(OFS[i], MAXV, RESP_OKAY);
		$display("saturation done");
		wr(8'h10, RESP_SLVERR);
		rd(8'h10, 32'h0, RESP_SLVERR);
		rd(OFS_CARRIER_MISSING, MAXV, RESP_OKAY);
		$display("unmapped access done");
		for (int i = 0; i < 4; i++) begin
			wr(OFS[i], RESP_OKAY);
			rd(OFS[i], 32'h0, RESP_OKAY);
		end
		$display("clearing done");
		fire(4'h8, 2);
		rd(OFS_RX_ERROR, 32'h2, RESP_OKAY);
		// event lands on the very edge that takes the clearing write
		ev <= 4'h8;
		@(posedge clk);
		ev <= 4'h0;
		wr(OFS_RX_ERROR, RESP_OKAY);
		rd(OFS_RX_ERROR, 32'h0, RESP_OKAY);
		$display("clear priority done");
		// a dropout and an error level held for several cycles count once each
		ev <= 4'h9;
		repeat (4) @(posedge clk);
		ev <= 4'h0;
		repeat (2) @(posedge clk);
		rd(OFS_CARRIER_MISSING, 32'h1, RESP_OKAY);
		rd(OFS_RX_ERROR, 32'h1, RESP_OKAY);
		$display("held level done");
		end_of_test();
	end

endmodule : tb
